//--- logic/fels_cfg.svh
// constants for the flash erase/lock sequencer host
// assumes a 25 MHz aclk and a x16 parallel flash on the pins
`ifndef FELS_CFG_SVH
`define FELS_CFG_SVH
`define FELS_CMD_READ_ARRAY 8'hFF
`define FELS_CMD_READ_STATUS 8'h70
`define FELS_CMD_CLEAR_STATUS 8'h50
`define FELS_CMD_CHIP_ERASE 8'h30
`define FELS_CMD_CONFIRM 8'hD0
`define FELS_CMD_LOCK_SETUP 8'h60
`define FELS_CMD_LOCK_BLOCK 8'h01
`define FELS_CMD_LOCK_PERM 8'hF1
`define FELS_SR_READY 7
`define FELS_SR_ERASE_ERR 5
`define FELS_SR_LOCK_ERR 4
`define FELS_SR_SUPPLY_ERR 3
`define FELS_SR_PROTECT 1
`define FELS_REG_CTRL 4'h0
`define FELS_REG_ADDR 4'h1
`define FELS_REG_STAT 4'h2
`define FELS_REG_SR 4'h3
`define FELS_REG_DATA 4'h4
`define FELS_BUS_CYCLES 3'h3
`endif

//--- logic/fels_pkg.sv
// types for the flash erase/lock sequencer host
// used with fels_cfg.svh
package fels_pkg;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_CHIP_ERASE = 3'h1,
    OP_LOCK_BLOCK = 3'h2,
    OP_LOCK_PERM = 3'h3,
    OP_CLEAR_LOCKS = 3'h4,
    OP_CLEAR_STATUS = 3'h5,
    OP_READ_ARRAY = 3'h6
  } fels_op_t;
  typedef enum logic [2:0] {
    RES_OK = 3'h0,
    RES_SUPPLY = 3'h1,
    RES_PROTECT = 3'h2,
    RES_SEQUENCE = 3'h3,
    RES_OP_FAIL = 3'h4
  } fels_res_t;
endpackage

//--- logic/fels_bus_cycle.sv
// one parallel bus cycle (write or read) on the flash pins
// assumes the flash meets its timing in FELS_BUS_CYCLES+1 clocks of strobe
`timescale 1ns/1ps
`include "fels_cfg.svh"
module fels_bus_cycle (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic is_write,
  input wire logic [20:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] dq_in,
  output logic [20:0] addr_pins,
  output logic [15:0] dq_out,
  output logic dq_oe,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [15:0] rdata,
  output logic done
);
  logic [2:0] cnt;
  logic busy;
  // strobe low for a fixed count, data captured at the end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 3'h0;
      busy <= 1'b0;
      done <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      dq_oe <= 1'b0;
      dq_out <= 16'h0000;
      addr_pins <= 21'h000000;
      rdata <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        busy <= 1'b1;
        cnt <= 3'h0;
        addr_pins <= addr;
        dq_out <= wdata;
        dq_oe <= is_write;
        ce_n <= 1'b0;
        we_n <= !is_write;
        oe_n <= is_write;
      end else if (busy) begin
        cnt <= cnt + 3'h1;
        if (cnt == `FELS_BUS_CYCLES) begin
          // we_n rises before data is released, giving hold time
          busy <= 1'b0;
          done <= 1'b1;
          ce_n <= 1'b1;
          we_n <= 1'b1;
          oe_n <= 1'b1;
          rdata <= dq_in;
        end
      end else begin
        dq_oe <= 1'b0;
      end
    end
  end
endmodule

//--- logic/fels_host.sv
// host sequencer: chip erase, lock set/clear, status check, read array
// assumes an AXI4-Lite master and a parallel flash on the pins
`timescale 1ns/1ps
`include "fels_cfg.svh"
module fels_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [20:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic reset_powerdown_pin_n
);
  import fels_pkg::*;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_CMD1 = 7'h02,
    ST_CMD2 = 7'h04,
    ST_POLL_CMD = 7'h08,
    ST_POLL_RD = 7'h10,
    ST_CHECK = 7'h20,
    ST_DONE = 7'h40
  } fels_state_t;

  fels_state_t state;
  fels_op_t op;
  fels_res_t result;
  logic [20:0] target_addr, cyc_addr;
  logic [7:0] status_register;
  logic busy, error_pending, start_req, arm_done;
  logic [2:0] req_op;
  logic cyc_start, cyc_write, cyc_done;
  logic [15:0] cyc_wdata, cyc_rdata, array_data;
  logic aw_held, w_held;
  logic [3:0] aw_idx, w_strb;
  logic [31:0] w_data;

  // status evaluation in check order, reserved bit 0 never looked at
  function automatic fels_res_t evaluate(input logic [7:0] sr, input fels_op_t o);
    if (sr[`FELS_SR_SUPPLY_ERR]) return RES_SUPPLY;
    if (sr[`FELS_SR_PROTECT]) return RES_PROTECT;
    if (sr[`FELS_SR_ERASE_ERR] && sr[`FELS_SR_LOCK_ERR]) return RES_SEQUENCE;
    if (o == OP_LOCK_BLOCK || o == OP_LOCK_PERM) begin
      if (sr[`FELS_SR_LOCK_ERR]) return RES_OP_FAIL;
    end else if (sr[`FELS_SR_ERASE_ERR]) begin
      return RES_OP_FAIL;
    end
    return RES_OK;
  endfunction

  // AXI write channels accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx <= s_axi_awaddr[5:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_idx == `FELS_REG_CTRL || aw_idx == `FELS_REG_ADDR) ?
                       2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes: control starts an op, address sets the target
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_req <= 1'b0;
      req_op <= 3'h0;
      target_addr <= 21'h000000;
      reset_powerdown_pin_n <= 1'b0;
    end else begin
      start_req <= 1'b0;
      if (aw_held && w_held && &w_strb) begin // whole-word writes only
        if (aw_idx == `FELS_REG_CTRL) begin
          reset_powerdown_pin_n <= !w_data[8];
          if (w_data[2:0] != 3'h0 && w_data[2:0] != 3'h7) begin
            start_req <= 1'b1;
            req_op <= w_data[2:0];
          end
        end else if (aw_idx == `FELS_REG_ADDR) begin
          target_addr <= w_data[20:0];
        end
      end
    end
  end

  // AXI read side, one word per register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr[5:2])
          `FELS_REG_CTRL: s_axi_rdata <= {23'h000000, !reset_powerdown_pin_n, 5'h00, op};
          `FELS_REG_ADDR: s_axi_rdata <= {11'h000, target_addr};
          `FELS_REG_STAT: s_axi_rdata <= {27'h0000000, error_pending, result, busy};
          `FELS_REG_SR: s_axi_rdata <= {24'h000000, status_register};
          `FELS_REG_DATA: s_axi_rdata <= {16'h0000, array_data};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // command sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      op <= OP_NONE;
      result <= RES_OK;
      busy <= 1'b0;
      error_pending <= 1'b0;
      status_register <= 8'h00;
      array_data <= 16'h0000;
      cyc_start <= 1'b0;
      cyc_write <= 1'b0;
      cyc_wdata <= 16'h0000;
      cyc_addr <= 21'h000000;
      arm_done <= 1'b0;
    end else begin
      cyc_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          // while an error is uncleared only clear status and read array are started
          if (start_req && reset_powerdown_pin_n &&
              (!error_pending || fels_op_t'(req_op) == OP_CLEAR_STATUS ||
               fels_op_t'(req_op) == OP_READ_ARRAY)) begin
            op <= fels_op_t'(req_op);
            busy <= 1'b1;
            state <= ST_CMD1;
            cyc_start <= 1'b1;
            cyc_write <= 1'b1;
            cyc_addr <= target_addr;
            case (fels_op_t'(req_op))
              OP_CHIP_ERASE: cyc_wdata <= {8'h00, `FELS_CMD_CHIP_ERASE};
              OP_LOCK_BLOCK, OP_LOCK_PERM, OP_CLEAR_LOCKS:
                cyc_wdata <= {8'h00, `FELS_CMD_LOCK_SETUP};
              OP_CLEAR_STATUS: cyc_wdata <= {8'h00, `FELS_CMD_CLEAR_STATUS};
              default: cyc_wdata <= {8'h00, `FELS_CMD_READ_ARRAY};
            endcase
          end
        end
        ST_CMD1: begin
          if (cyc_done) begin
            cyc_start <= 1'b1;
            if (op == OP_CLEAR_STATUS) begin
              error_pending <= 1'b0;
              status_register <= 8'h00;
              cyc_start <= 1'b0;
              state <= ST_DONE;
            end else if (op == OP_READ_ARRAY) begin
              cyc_write <= 1'b0;
              state <= ST_POLL_RD;
              arm_done <= 1'b1;
            end else begin
              state <= ST_CMD2;
              case (op)
                OP_LOCK_BLOCK: cyc_wdata <= {8'h00, `FELS_CMD_LOCK_BLOCK};
                OP_LOCK_PERM: cyc_wdata <= {8'h00, `FELS_CMD_LOCK_PERM};
                default: cyc_wdata <= {8'h00, `FELS_CMD_CONFIRM};
              endcase
            end
          end
        end
        ST_CMD2: begin
          // switch to status reads after confirm
          if (cyc_done) begin
            cyc_start <= 1'b1;
            cyc_wdata <= {8'h00, `FELS_CMD_READ_STATUS};
            state <= ST_POLL_CMD;
          end
        end
        ST_POLL_CMD: begin
          if (cyc_done) begin
            cyc_start <= 1'b1;
            cyc_write <= 1'b0;
            state <= ST_POLL_RD;
          end
        end
        ST_POLL_RD: begin
          if (cyc_done) begin
            if (arm_done) begin
              arm_done <= 1'b0;
              array_data <= cyc_rdata;
              state <= ST_DONE;
            end else if (cyc_rdata[`FELS_SR_READY]) begin
              // reserved bit dropped from the copy
              status_register <= {cyc_rdata[7:1], 1'b0};
              state <= ST_CHECK;
            end else begin
              cyc_start <= 1'b1;
            end
          end
        end
        ST_CHECK: begin
          // flags accumulate, so a result covers earlier ops too
          result <= evaluate(status_register, op);
          error_pending <= evaluate(status_register, op) != RES_OK;
          state <= ST_DONE;
        end
        ST_DONE: begin
          busy <= 1'b0;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  fels_bus_cycle u_cycle (
    .aclk(aclk), .aresetn(aresetn), .start(cyc_start), .is_write(cyc_write),
    .addr(cyc_addr), .wdata(cyc_wdata), .dq_in(flash_dq_in), .addr_pins(flash_addr),
    .dq_out(flash_dq_out), .dq_oe(flash_dq_oe), .ce_n(flash_ce_n), .we_n(flash_we_n),
    .oe_n(flash_oe_n), .rdata(cyc_rdata), .done(cyc_done)
  );
endmodule

//--- verif/fels_host_monitor.sv
// bus and pin timing checks for the sequencer host
// assumes it is bound into fels_host and sees its ports only
`timescale 1ns/1ps
module fels_host_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic flash_we_n,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_dq_oe,
  input wire logic [15:0] flash_dq_out,
  input wire logic [20:0] flash_addr,
  input wire logic reset_powerdown_pin_n,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  // one clock domain, so one default for all
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_we_sel;
    !flash_we_n |-> !flash_ce_n && flash_dq_oe && flash_oe_n;
  endproperty
  a_we_sel: assert property (p_we_sel)
    else $error("write strobe without select");
  property p_we_len;
    $fell(flash_we_n) |-> !flash_we_n [*4] ##1 flash_we_n;
  endproperty
  a_we_len: assert property (p_we_len)
    else $error("write strobe length");
  property p_oe_hold;
    $rose(flash_we_n) |-> flash_dq_oe ##1 !flash_dq_oe;
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("data drive release");
  property p_rd_len;
    $fell(flash_oe_n) |-> (!flash_oe_n && !flash_ce_n && !flash_dq_oe) [*4] ##1 flash_oe_n;
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read strobe length");
  property p_wr_stable;
    !flash_we_n && !$past(flash_we_n) |-> $stable(flash_dq_out) && $stable(flash_addr);
  endproperty
  a_wr_stable: assert property (p_wr_stable)
    else $error("command changed under strobe");
  property p_rp_quiet;
    !reset_powerdown_pin_n |-> flash_we_n;
  endproperty
  a_rp_quiet: assert property (p_rp_quiet)
    else $error("write while device held in reset");
  property p_b_lat;
    s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat)
    else $error("write response late");
  property p_b_stand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_stand: assert property (p_b_stand)
    else $error("write response dropped");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read data late");
  property p_r_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stand: assert property (p_r_stand)
    else $error("read data dropped");
endmodule

bind fels_host fels_host_chk u_chk (.aclk(aclk), .aresetn(aresetn), .flash_we_n(flash_we_n),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_dq_oe(flash_dq_oe),
  .flash_dq_out(flash_dq_out), .flash_addr(flash_addr),
  .reset_powerdown_pin_n(reset_powerdown_pin_n), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

//--- verif/fels_flash_model.sv
// behavioural flash device on the parallel pins
// assumes strobes and data settle on aclk edges
`timescale 1ns/1ps
module fels_flash_model (
  input wire logic aclk,
  input wire logic [20:0] addr,
  input wire logic [15:0] dq,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic rp_n,
  input wire logic vpp_ok,
  input wire logic seq_bad,
  input wire logic [7:0] dly,
  output logic [15:0] dq_in
);
  logic [7:0] sr = 8'h80;
  logic [7:0] pend = 8'h00;
  logic [7:0] d = 8'h00;
  logic [31:0] lk = 32'h0;
  logic perm = 1'h0;
  logic st = 1'h0;
  logic we_q = 1'h1;
  int cnt = 0;
  always @(posedge aclk) begin
    if (cnt > 0) cnt--;
    d = dq[7:0];
    if (!rp_n) begin
      sr = 8'h80;
      pend = 8'h00;
      st = 1'h0;
    end else if (!we_q && we_n && cnt == 0) begin
      if (pend != 8'h00) begin
        st = 1'h1;
        cnt = dly;
        if (seq_bad || !(d == 8'hD0 || pend == 8'h60 && (d == 8'h01 || d == 8'hF1)))
          sr |= 8'h30;
        else if (pend == 8'h30 ? lk != 32'h0 : perm && d != 8'hF1)
          sr |= 8'h02;
        else if (!vpp_ok)
          sr |= (pend == 8'h60 && d != 8'hD0) ? 8'h18 : 8'h28;
        else if (pend == 8'h60 && d == 8'h01)
          lk[addr[20:16]] = 1'h1;
        else if (pend == 8'h60 && d == 8'hF1)
          perm = 1'h1;
        else if (pend == 8'h60)
          lk = 32'h0;
        pend = 8'h00;
      end else begin
        case (d)
          8'h30, 8'h60: pend = d;
          8'h70: st = 1'h1;
          8'h50: sr = 8'h80;
          8'hFF: st = 1'h0;
          default: ;
        endcase
      end
    end
    we_q = we_n;
    // ready bit; reserved bit set and bus inverted when idle
    dq_in <= (!ce_n && !oe_n) ? (st ? {8'h00, cnt == 0, sr[6:1], 1'h1}
      : addr[15:0] ^ 16'hA5A5) : ~dq_in;
  end
endmodule

//--- verif/fels_host_bench.sv
// self-checking bench for the sequencer host
// assumes the flash model and the bound checker
`timescale 1ns/1ps
module fels_host_bench;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, r;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [20:0] flash_addr;
  logic [15:0] flash_dq_out, flash_dq_in;
  logic flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, reset_powerdown_pin_n;
  logic vpp_ok = 1'h1, seq_bad = 1'h0;
  logic [7:0] dly = 8'h05;
  int miscompares = 0, checks_done = 0, seed = 28, perm = 0, pend = 0, last = 0;
  int lq[$];
  always #20 aclk = ~aclk;
  fels_host dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
    .reset_powerdown_pin_n(reset_powerdown_pin_n));
  fels_flash_model flash (.aclk, .addr(flash_addr), .dq(flash_dq_out), .ce_n(flash_ce_n),
    .we_n(flash_we_n), .oe_n(flash_oe_n), .rp_n(reset_powerdown_pin_n), .vpp_ok,
    .seq_bad, .dly, .dq_in(flash_dq_in));
  task automatic chk(logic [31:0] g, logic [31:0] e, string m);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, m, g, e);
    end
  endtask
  // address and data offered together, each released when taken
  task automatic wr(logic [31:0] a, logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, (a[5:2] < 4'h2) ? 32'h0 : 32'h2, "bresp");
  endtask
  task automatic rd(logic [31:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  // run one operation, then predict its outcome from the model state
  task automatic op(logic [2:0] o, logic [31:0] a);
    int er;
    int es;
    int ep;
    bit blk;
    wr(32'h4, a);
    wr(32'h0, {29'h0, o});
    do rd(32'h8, r); while (r[0] !== 1'h0);
    // refused ops and clear status / read array leave the result as it was
    es = -1;
    er = last;
    ep = (o == 5) ? 0 : pend;
    blk = (o == 1) ? lq.size() > 0 : (o != 3 && perm);
    if (o < 5 && !pend && seq_bad) begin
      er = 3;
      es = 'hB0;
      ep = 1;
    end else if (o < 5 && !pend) begin
      er = blk ? 2 : vpp_ok ? 0 : 1;
      es = er == 2 ? 'h82 : er ? ((o == 2 || o == 3) ? 'h98 : 'hA8) : 'h80;
      ep = er != 0;
      if (!er && o == 2) lq.push_back(a[20:16]);
      if (!er && o == 3) perm = 1;
      if (!er && o == 4) lq.delete();
    end
    chk(r[4:1], {28'h0, ep[0], er[2:0]}, "stat");
    if (es >= 0) rd(32'hC, r);
    if (es >= 0) chk(r[7:0], es[7:0], "sr");
    pend = ep;
    last = er;
    $display("op %0d done", o);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    miscompares++;
    give_verdict;
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    wr(32'h0, 32'h0);
    chk(reset_powerdown_pin_n, 32'h1, "pin");
    op(2, 32'h30000);
    op(2, 32'h50000);
    op(1, 32'h0);
    op(1, 32'h0);
    op(5, 32'h0);
    op(4, 32'h0);
    op(6, 32'h1C3A5);
    rd(32'h10, r);
    chk(r[15:0], 16'hA5A5 ^ 16'hC3A5, "array");
    dly <= 8'h05 + 8'($random(seed) & 'h3F);
    op(1, 32'h0);
    vpp_ok <= 1'h0;
    op(2, 32'($random(seed)) & 32'h1FFFFF);
    op(5, 32'h0);
    vpp_ok <= 1'h1;
    seq_bad <= 1'h1;
    op(1, 32'h0);
    seq_bad <= 1'h0;
    op(5, 32'h0);
    op(3, 32'h0);
    op(2, 32'h20000);
    op(5, 32'h0);
    op(4, 32'h0);
    op(5, 32'h0);
    rd(32'h0, r);
    chk(r, 32'h5, "ctrl");
    wr(32'h0, 32'h100);
    chk(reset_powerdown_pin_n, 32'h0, "pin low");
    rd(32'h0, r);
    chk(r, 32'h105, "ctrl pin");
    wr(32'h0, 32'h0);
    chk(reset_powerdown_pin_n, 32'h1, "pin high");
    wr(32'h8, 32'h0);
    rd(32'h20, r);
    chk(r, 32'h0, "unmapped data");
    chk(rr, 32'h2, "unmapped resp");
    give_verdict;
  end
endmodule
